// ===== l2c_pkg.sv
// Constants and types shared by the second level cache controller
package l2c_pkg;

	// --------------------------------------------------------------
	// Register offsets (byte addresses)
	// --------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DIAGNOSTIC_TAG_PATTERN = 8'h04;
	localparam logic [7:0] OFF_TIMING = 8'h08;
	localparam logic [7:0] OFF_LOG_TAG = 8'h0c;
	localparam logic [7:0] OFF_LOG_ADDR = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;

	// --------------------------------------------------------------
	// Control and timing register field positions
	// --------------------------------------------------------------
	localparam int CTL_UPD_CASTOUT = 0;
	localparam int CTL_PAR_CHK_EN = 1;
	localparam int CTL_FORCE_DIAG = 2;
	localparam int CTL_SW_POL = 3;
	localparam int CTL_GAP_LO = 4;
	localparam int CTL_TAGMASK_LO = 6;
	localparam int CTL_TAGMASK_HI = 12;
	localparam int CTL_DWMODE = 13;
	localparam int TIM_PRECHG_LO = 0;
	localparam int TIM_DIVISOR_LO = 4;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [13:0] CTRL_RST = 14'h0002;
	localparam logic [0:14] DIAGNOSTIC_TAG_PATTERN_RST = 15'h7fff;
	localparam logic [7:0] TIMING_RST = 8'h00;

	// --------------------------------------------------------------
	// Cycle counts
	// --------------------------------------------------------------
	localparam logic [7:0] LOOKUP_CYC = 8'h03;
	localparam logic [7:0] TAGWR_CYC = 8'h02;
	localparam logic [7:0] HANDOFF_BASE = 8'h02;
	localparam logic [7:0] PRECHG_BASE = 8'h01;
	localparam logic [7:0] DIVISOR_BASE = 8'h02;

	// --------------------------------------------------------------
	// Transaction kinds from the queues
	// --------------------------------------------------------------
	localparam logic [2:0] KIND_CACHED_MISS = 3'h0;
	localparam logic [2:0] KIND_UNC_LOAD = 3'h1;
	localparam logic [2:0] KIND_DMA_READ = 3'h2;
	localparam logic [2:0] KIND_CASTOUT = 3'h3;
	localparam logic [2:0] KIND_UNC_STORE = 3'h4;
	localparam logic [2:0] KIND_LOAD_CLEAR = 3'h5;
	localparam logic [2:0] KIND_DMA_WRITE = 3'h6;

	// Cache actions a transaction reduces to
	typedef enum logic [1:0] {ACT_FILL, ACT_BYPASS, ACT_CASTOUT_FILL, ACT_INVAL} l2c_act_t;

	// Controller states
	typedef enum logic [3:0] {
		ST_IDLE, ST_LOOKUP, ST_FWD, ST_OE_OFF, ST_SW_CLOSE, ST_MEM, ST_SW_OPEN, ST_TAG_WR
	} l2c_state_t;

endpackage

// ===== l2c_tag_bus_ctl.sv
// Second level cache tag compare, tag update and shared data bus handover
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module l2c_tag_bus_ctl (
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic TXN_VALID,
	input wire logic [2:0] TXN_KIND,
	input wire logic [0:28] TXN_ADDR,
	output logic TXN_READY,
	output logic [6:26] CACHE_ADDR,
	input wire logic [0:14] TAG_IN,
	output logic [0:14] TAG_OUT,
	output logic TAG_OE_N,
	output logic TAG_READ_EN,
	output logic TAG_WE,
	output logic DATA_OE,
	output logic DATA_WE,
	output logic [1:0] BUS_SWITCH_CTL,
	output logic HIT_FWD,
	output logic MC_START,
	output logic MC_GRANT,
	input wire logic MC_WSTROBE,
	input wire logic MC_DONE
);

	// --------------------------------------------------------------
	// State record
	// --------------------------------------------------------------
	typedef struct packed {
		l2c_pkg::l2c_state_t state;
		l2c_pkg::l2c_act_t act;
		logic [0:28] addr;
		logic [7:0] cnt;
		logic tag_wr_pend;
		logic [0:14] wr_tag;
		logic [6:26] cache_addr;
		logic data_oe;
		logic tag_rd;
		logic tag_we;
		logic tag_oe_n;
		logic [0:14] tag_out;
		logic sw_closed;
		logic [1:0] sw_pins;
		logic grant;
		logic mc_start;
		logic hit_fwd;
		logic data_we;
		logic ready;
		logic [13:0] ctrl;
		logic [0:14] diagnostic_tag_pattern;
		logic [7:0] timing;
		logic log_valid;
		logic log_hit;
		logic [0:14] log_tag;
		logic [0:28] log_addr;
		logic [31:0] rdata;
		logic [0:14] tag_s1;
		logic [0:14] tag_s2;
	} l2c_regs_t;

	l2c_regs_t q;
	l2c_regs_t d;

	// Configuration fields and derived tag, compare and read signals
	logic upd_castout;
	logic chk_en;
	logic force_diag;
	logic dwmode;
	logic [7:0] gap_sw;
	logic [7:0] gap_prechg;
	logic [7:0] gap_divisor;
	logic [0:14] sig_force;
	logic [0:13] tag_forced;
	logic [0:14] new_tag;
	logic [0:14] cmp_tag;
	logic [0:14] cmp_mask;
	logic tag_hit;
	logic par_err;
	l2c_pkg::l2c_act_t kind_act;
	logic [31:0] rd_mux;

	assign upd_castout = q.ctrl[l2c_pkg::CTL_UPD_CASTOUT];
	assign chk_en = q.ctrl[l2c_pkg::CTL_PAR_CHK_EN];
	assign force_diag = q.ctrl[l2c_pkg::CTL_FORCE_DIAG];
	assign dwmode = q.ctrl[l2c_pkg::CTL_DWMODE];

	// Handover gaps: two plus gap field, precharge and divisor terms
	assign gap_sw = l2c_pkg::HANDOFF_BASE + {6'h00, q.ctrl[l2c_pkg::CTL_GAP_LO +: 2]};
	assign gap_prechg = l2c_pkg::PRECHG_BASE + {4'h0, q.timing[l2c_pkg::TIM_PRECHG_LO +: 4]};
	assign gap_divisor = 8'((l2c_pkg::DIVISOR_BASE
		+ {4'h0, q.timing[l2c_pkg::TIM_DIVISOR_LO +: 4]}) << 1);

	// --------------------------------------------------------------
	// Tag formation
	// --------------------------------------------------------------
	// Address bits 6..12 belong to the index when the mask bit is set
	genvar gi;
	generate
		for (gi = 0; gi < 15; gi++)
		begin : g_sig
			if (gi >= 6 && gi <= 12)
			begin : g_mask
				assign sig_force[gi] = q.ctrl[gi];
			end
			else if (gi == 13)
			begin : g_dw
				assign sig_force[gi] = dwmode;
			end
			else
			begin : g_fix
				assign sig_force[gi] = 1'b0;
			end
		end
	endgenerate

	// Insignificant tag bits forced to one, odd parity appended
	assign tag_forced = q.addr[0:13] | sig_force[0:13];
	assign new_tag = {tag_forced, ~^tag_forced};
	// Compare value: diagnostic pattern when forced, else computed tag
	assign cmp_tag = force_diag ? q.diagnostic_tag_pattern : new_tag;
	assign cmp_mask = {14'h3fff, chk_en};
	assign tag_hit = ((q.tag_s2 ^ cmp_tag) & cmp_mask) == 15'h0000;
	assign par_err = ~^q.tag_s2;

	// Reduce the transaction kind to a cache action
	always_comb
	begin
		case (TXN_KIND)
			l2c_pkg::KIND_CACHED_MISS: kind_act = l2c_pkg::ACT_FILL;
			l2c_pkg::KIND_UNC_LOAD,
			l2c_pkg::KIND_DMA_READ: kind_act = l2c_pkg::ACT_BYPASS;
			l2c_pkg::KIND_CASTOUT: kind_act = upd_castout ? l2c_pkg::ACT_CASTOUT_FILL
				: l2c_pkg::ACT_INVAL;
			default: kind_act = l2c_pkg::ACT_INVAL;
		endcase
	end

	// Register read multiplexer, unmapped reads give zero
	always_comb
	begin
		case (REG_ADDR)
			l2c_pkg::OFF_CTRL: rd_mux = {18'h00000, q.ctrl};
			l2c_pkg::OFF_DIAGNOSTIC_TAG_PATTERN: rd_mux = {17'h00000, q.diagnostic_tag_pattern};
			l2c_pkg::OFF_TIMING: rd_mux = {24'h000000, q.timing};
			l2c_pkg::OFF_LOG_TAG: rd_mux = {14'h0000, q.log_valid, q.log_hit, 1'b0, q.log_tag};
			l2c_pkg::OFF_LOG_ADDR: rd_mux = {3'h0, q.log_addr};
			l2c_pkg::OFF_STATUS: rd_mux = {24'h000000, q.state, q.sw_closed, q.grant,
				q.tag_wr_pend, ~q.ready};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// --------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.tag_s1 = TAG_IN;
		d.tag_s2 = q.tag_s1;
		d.rdata = REG_RD ? rd_mux : 32'h00000000;
		d.mc_start = 1'b0;
		d.hit_fwd = 1'b0;
		d.data_we = 1'b0;
		d.tag_we = 1'b0;
		// Register writes
		if (REG_WR)
		begin
			case (REG_ADDR)
				l2c_pkg::OFF_CTRL: d.ctrl = REG_WDATA[13:0];
				l2c_pkg::OFF_DIAGNOSTIC_TAG_PATTERN: d.diagnostic_tag_pattern = REG_WDATA[14:0];
				l2c_pkg::OFF_TIMING: d.timing = REG_WDATA[7:0];
				l2c_pkg::OFF_LOG_TAG: d.log_valid = 1'b0;
				default: d.ctrl = q.ctrl;
			endcase
		end
		case (q.state)
			l2c_pkg::ST_IDLE:
			begin
				if (TXN_VALID && q.ready)
				begin
					d.ready = 1'b0;
					d.addr = TXN_ADDR;
					d.act = kind_act;
					d.tag_wr_pend = 1'b0;
					// Index bits: tag-side bits forced one, bit 13 from mode
					d.cache_addr = {TXN_ADDR[6:12] | ~sig_force[6:12], dwmode ? TXN_ADDR[13]
						: TXN_ADDR[28], TXN_ADDR[14:26]};
					if (kind_act == l2c_pkg::ACT_BYPASS)
					begin
						d.state = l2c_pkg::ST_OE_OFF;
						d.cnt = gap_sw;
					end
					else if (kind_act == l2c_pkg::ACT_CASTOUT_FILL)
					begin
						d.state = l2c_pkg::ST_OE_OFF;
						d.cnt = gap_sw;
						d.tag_wr_pend = 1'b1;
						d.wr_tag = force_diag ? q.diagnostic_tag_pattern
							: {TXN_ADDR[0:13] | sig_force[0:13],
							~^(TXN_ADDR[0:13] | sig_force[0:13])};
					end
					else
					begin
						// Tag and data arrays read together, switch open
						d.state = l2c_pkg::ST_LOOKUP;
						d.cnt = l2c_pkg::LOOKUP_CYC;
						d.data_oe = 1'b1;
						d.tag_rd = 1'b1;
					end
				end
			end
			l2c_pkg::ST_LOOKUP:
			begin
				d.cnt = q.cnt - 8'h01;
				if (q.cnt == 8'h01)
				begin
					d.tag_rd = 1'b0;
					// Log first bad tag, or every read in diagnostic mode
					if ((par_err && !q.log_valid) || force_diag)
					begin
						d.log_valid = 1'b1;
						d.log_hit = tag_hit;
						d.log_tag = q.tag_s2;
						d.log_addr = q.addr;
					end
					if (q.act == l2c_pkg::ACT_FILL && tag_hit)
					begin
						d.state = l2c_pkg::ST_FWD;
						d.hit_fwd = 1'b1;
					end
					else
					begin
						// Miss or store-like: cache stops driving first
						d.state = l2c_pkg::ST_OE_OFF;
						d.cnt = gap_sw;
						d.data_oe = 1'b0;
						if (q.act == l2c_pkg::ACT_FILL)
						begin
							d.tag_wr_pend = 1'b1;
							d.wr_tag = force_diag ? q.diagnostic_tag_pattern : new_tag;
						end
						else if (tag_hit)
						begin
							d.tag_wr_pend = 1'b1;
							d.wr_tag = q.diagnostic_tag_pattern;
						end
					end
				end
			end
			l2c_pkg::ST_FWD:
			begin
				d.data_oe = 1'b0;
				d.state = l2c_pkg::ST_IDLE;
				d.ready = 1'b1;
			end
			l2c_pkg::ST_OE_OFF:
			begin
				d.cnt = q.cnt - 8'h01;
				if (q.cnt <= 8'h01)
				begin
					// Cache quiet long enough: close switch
					d.state = l2c_pkg::ST_SW_CLOSE;
					d.sw_closed = 1'b1;
					d.cnt = (gap_prechg > gap_sw) ? gap_prechg : gap_sw;
				end
			end
			l2c_pkg::ST_SW_CLOSE:
			begin
				d.cnt = q.cnt - 8'h01;
				if (q.cnt <= 8'h01)
				begin
					d.state = l2c_pkg::ST_MEM;
					d.grant = 1'b1;
					d.mc_start = 1'b1;
				end
			end
			l2c_pkg::ST_MEM:
			begin
				// Capture write or copyin data into the data SRAMs
				d.data_we = MC_WSTROBE && (q.act == l2c_pkg::ACT_FILL
					|| q.act == l2c_pkg::ACT_CASTOUT_FILL);
				if (MC_DONE)
				begin
					d.grant = 1'b0;
					d.sw_closed = 1'b0;
					d.state = l2c_pkg::ST_SW_OPEN;
					d.cnt = (gap_divisor > gap_sw) ? gap_divisor : gap_sw;
				end
			end
			l2c_pkg::ST_SW_OPEN:
			begin
				d.cnt = q.cnt - 8'h01;
				if (q.cnt <= 8'h01)
				begin
					if (q.tag_wr_pend)
					begin
						d.state = l2c_pkg::ST_TAG_WR;
						d.cnt = l2c_pkg::TAGWR_CYC;
						d.tag_oe_n = 1'b0;
						d.tag_we = 1'b1;
						d.tag_out = q.wr_tag;
					end
					else
					begin
						d.state = l2c_pkg::ST_IDLE;
						d.ready = 1'b1;
					end
				end
			end
			l2c_pkg::ST_TAG_WR:
			begin
				d.cnt = q.cnt - 8'h01;
				if (q.cnt <= 8'h01)
				begin
					// Next transaction only after tag write completes
					d.tag_oe_n = 1'b1;
					d.tag_wr_pend = 1'b0;
					d.state = l2c_pkg::ST_IDLE;
					d.ready = 1'b1;
				end
			end
			default:
			begin
				d.state = l2c_pkg::ST_IDLE;
				d.ready = 1'b1;
			end
		endcase
		// Switch control pins follow polarity selection
		d.sw_pins = {2{d.sw_closed ^ d.ctrl[l2c_pkg::CTL_SW_POL]}};
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			q <= '0;
			q.state <= l2c_pkg::ST_IDLE;
			q.act <= l2c_pkg::ACT_FILL;
			q.ready <= 1'b1;
			q.tag_oe_n <= 1'b1;
			q.ctrl <= l2c_pkg::CTRL_RST;
			q.diagnostic_tag_pattern <= l2c_pkg::DIAGNOSTIC_TAG_PATTERN_RST;
			q.timing <= l2c_pkg::TIMING_RST;
			q.sw_pins <= 2'h0;
		end
		else
		begin
			q <= d;
		end
	end

	// Outputs straight from the state record
	assign REG_RDATA = q.rdata;
	assign TXN_READY = q.ready;
	assign CACHE_ADDR = q.cache_addr;
	assign TAG_OUT = q.tag_out;
	assign TAG_OE_N = q.tag_oe_n;
	assign TAG_READ_EN = q.tag_rd;
	assign TAG_WE = q.tag_we;
	assign DATA_OE = q.data_oe;
	assign DATA_WE = q.data_we;
	assign BUS_SWITCH_CTL = q.sw_pins;
	assign HIT_FWD = q.hit_fwd;
	assign MC_START = q.mc_start;
	assign MC_GRANT = q.grant;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	// Cycles since the cache stopped driving and since the switch opened
	logic [7:0] oe_low_cnt_q;
	logic [7:0] sw_open_cnt_q;
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			oe_low_cnt_q <= 8'hff;
			sw_open_cnt_q <= 8'hff;
		end
		else
		begin
			oe_low_cnt_q <= q.data_oe ? 8'h00 : ((oe_low_cnt_q == 8'hff) ? 8'hff
				: oe_low_cnt_q + 8'h01);
			sw_open_cnt_q <= q.sw_closed ? 8'h00 : ((sw_open_cnt_q == 8'hff) ? 8'hff
				: sw_open_cnt_q + 8'h01);
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RESETN);

	sequence s_accept_bypass;
		q.state == l2c_pkg::ST_IDLE && TXN_VALID && q.ready
			&& kind_act == l2c_pkg::ACT_BYPASS;
	endsequence
	sequence s_no_lookup;
		(!q.tag_rd && !q.data_oe) [*4];
	endsequence

	chk_oe_switch_excl: assert property (q.data_oe |-> !q.sw_closed)
		else $error("cache drives while switch closed");
	chk_grant_switch: assert property (q.grant |-> q.sw_closed && !q.data_oe)
		else $error("memory controller granted with switch open");
	chk_close_gap: assert property ($rose(q.sw_closed) |-> oe_low_cnt_q >= gap_sw)
		else $error("switch closed too soon after cache release");
	chk_cache_on_gap: assert property ($rose(q.data_oe) |-> sw_open_cnt_q >= gap_sw)
		else $error("cache enabled too soon after switch open");
	chk_bypass_path: assert property (s_accept_bypass |=> s_no_lookup)
		else $error("bypass transaction touched the cache");
	chk_tag_parity: assert property (q.tag_we && !force_diag && q.act == l2c_pkg::ACT_FILL
		|-> ^q.tag_out == 1'b1)
		else $error("new tag written with even parity");
	chk_tagwr_block: assert property (q.state == l2c_pkg::ST_TAG_WR |-> !q.ready)
		else $error("transaction accepted during tag write");
	chk_hit_pulse: assert property (q.hit_fwd |-> $past(q.state) == l2c_pkg::ST_LOOKUP
		##1 !q.hit_fwd)
		else $error("hit forward not a single pulse after lookup");
	chk_log_hold: assert property ($past(q.log_valid) && !force_diag && !$past(REG_WR)
		|-> $stable(q.log_tag))
		else $error("logged tag overwritten");
	chk_switch_pol: assert property (q.sw_pins[0] == (q.sw_closed
		^ q.ctrl[l2c_pkg::CTL_SW_POL]))
		else $error("switch pin polarity wrong");

endmodule
`default_nettype wire

// ===== l2c_mem_model.sv
// Far-side model: tag SRAM array and DRAM memory controller
`timescale 1ns/1ps
`default_nettype none
module l2c_mem_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [6:26] cache_addr,
	input wire logic tag_read_en,
	input wire logic tag_we,
	input wire logic [0:14] tag_out,
	output logic [0:14] tag_in,
	input wire logic flip_par,
	input wire logic [3:0] delay,
	input wire logic mc_start,
	output logic mc_wstrobe,
	output logic mc_done
);
	logic [0:14] mem [0:127];
	logic [0:14] last_q;
	int cnt;

	// Async tag read; a released bus shows the inverse of its last value
	assign tag_in = tag_read_en ? mem[cache_addr[20:26]] ^ {14'h0, flip_par} : ~last_q;

	initial
	begin
		for (int i = 0; i < 128; i++)
			mem[i] = 15'h7fff;
	end

	// Tag write and bus history
	always @(posedge clk)
	begin
		if (tag_we)
			mem[cache_addr[20:26]] <= tag_out;
		last_q <= tag_in;
	end

	// Memory controller: variable delay, two write strobes, then done
	always @(posedge clk or negedge rst_n)
	begin
		mc_wstrobe <= 1'b0;
		mc_done <= 1'b0;
		if (!rst_n)
			cnt <= 0;
		else if (mc_start)
			cnt <= delay + 4;
		else if (cnt > 0)
		begin
			cnt <= cnt - 1;
			mc_wstrobe <= cnt == 3 || cnt == 2;
			mc_done <= cnt == 1;
		end
	end
endmodule
`default_nettype wire

// ===== l2c_tag_bus_ctl_tb_top.sv
// Self-checking bench for the cache tag and bus controller
`timescale 1ns/1ps
`default_nettype none
module l2c_tag_bus_ctl_tb_top;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic txn_valid = 1'b0;
	logic [2:0] txn_kind = 3'h0;
	logic [0:28] txn_addr = 29'h0;
	logic flip_par = 1'b0;
	logic [3:0] delay = 4'h0;
	logic [31:0] reg_rdata;
	logic [6:26] cache_addr;
	logic [0:14] tag_in, tag_out;
	logic [1:0] bus_sw;
	logic txn_ready, tag_oe_n, tag_read_en, tag_we, data_oe, data_we, hit_fwd;
	logic mc_start, mc_grant, mc_wstrobe, mc_done, sw;
	logic pol = 1'b0;
	logic sw_q = 1'b0, oe_q = 1'b0, gr_q = 1'b0, to_q = 1'b1;
	int oe_off = 99, sw_cl = 0, sw_op = 99, gr_off = 99;
	int error_cnt = 0;
	int checks = 0;
	logic [13:0] ctrl = 14'h0002;
	logic [7:0] tim = 8'h00;
	logic [0:14] diag = 15'h7fff;
	logic [0:14] ref_tag [0:127];

	always #25 mclk = ~mclk;

	l2c_tag_bus_ctl i_l2c_tag_bus_ctl (
		.MCLK(mclk),
		.RESETN(resetn),
		.REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata),
		.REG_WR(reg_wr),
		.REG_RD(reg_rd),
		.REG_RDATA(reg_rdata),
		.TXN_VALID(txn_valid),
		.TXN_KIND(txn_kind),
		.TXN_ADDR(txn_addr),
		.TXN_READY(txn_ready),
		.CACHE_ADDR(cache_addr),
		.TAG_IN(tag_in),
		.TAG_OUT(tag_out),
		.TAG_OE_N(tag_oe_n),
		.TAG_READ_EN(tag_read_en),
		.TAG_WE(tag_we),
		.DATA_OE(data_oe),
		.DATA_WE(data_we),
		.BUS_SWITCH_CTL(bus_sw),
		.HIT_FWD(hit_fwd),
		.MC_START(mc_start),
		.MC_GRANT(mc_grant),
		.MC_WSTROBE(mc_wstrobe),
		.MC_DONE(mc_done)
	);

	l2c_mem_model i_l2c_mem_model (
		.clk(mclk),
		.rst_n(resetn),
		.cache_addr(cache_addr),
		.tag_read_en(tag_read_en),
		.tag_we(tag_we),
		.tag_out(tag_out),
		.tag_in(tag_in),
		.flip_par(flip_par),
		.delay(delay),
		.mc_start(mc_start),
		.mc_wstrobe(mc_wstrobe),
		.mc_done(mc_done)
	);

	// ----------------------------------------
	// Compare, report and bus tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// Switch polarity as the design holds it, from the landing edge on
		if (a == l2c_pkg::OFF_CTRL)
			pol = d[3];
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
		@(negedge mclk);
		chk("rdata_zero", reg_rdata, 32'h0);
	endtask

	// Expected tag: masked bits forced one, odd parity, or the forced pattern
	function automatic logic [0:14] exp_tag(input logic [0:28] a);
		logic [0:14] t;
		t = {a[0:13], 1'b0};
		for (int i = 6; i < 14; i++)
			if (ctrl[i])
				t[i] = 1'b1;
		t[14] = ~^t[0:13];
		return ctrl[2] ? diag : t;
	endfunction

	// One transaction, checked against the reference tag array
	task automatic txn(input logic [2:0] k, input logic [0:28] a);
		logic [0:14] et, tv, wv;
		logic [6:26] ea;
		logic hit, fill, byp, cof, inv, upd, tw, rdn, done;
		int hk, ns, nw;
		et = exp_tag(a);
		tv = ref_tag[a[20:26]] ^ {14'h0, flip_par};
		hit = ctrl[1] ? tv === et : tv[0:13] === et[0:13];
		fill = k == l2c_pkg::KIND_CACHED_MISS;
		byp = k == l2c_pkg::KIND_UNC_LOAD || k == l2c_pkg::KIND_DMA_READ;
		cof = k == l2c_pkg::KIND_CASTOUT && ctrl[0];
		inv = !fill && !byp && !cof;
		upd = cof || fill && !hit || inv && hit;
		{hk, ns, nw} = '0;
		{tw, rdn, done} = 3'h0;
		// Expected cache address: tag-side bits forced one
		ea = {a[6:12], ctrl[13] ? a[13] : a[28], a[14:26]};
		for (int i = 6; i < 13; i++)
			if (!ctrl[i])
				ea[i] = 1'b1;
		@(posedge mclk);
		txn_valid <= 1'b1;
		txn_kind <= k;
		txn_addr <= a;
		delay <= 4'($urandom % 4);
		@(posedge mclk);
		txn_valid <= 1'b0;
		for (int c = 1; !done; c++)
		begin
			@(negedge mclk);
			if (c == 1)
				chk("cache_addr", cache_addr, ea);
			if (hit_fwd)
				hk = c;
			ns += mc_start;
			nw += data_we;
			rdn |= tag_read_en;
			if (tag_we)
				wv = tag_out;
			tw |= tag_we;
			done = txn_ready;
			if (c > 400)
			begin
				chk("timeout", 1, 0);
				results;
			end
		end
		chk("hit_cycle", hk, fill && hit ? 4 : 0);
		chk("mem_start", ns, fill && hit ? 0 : 1);
		chk("data_write", nw, cof || fill && !hit ? 2 : 0);
		chk("lookup", rdn, !byp && !cof);
		chk("tag_write", tw, upd);
		if (tw)
			chk("tag_value", wv, inv ? diag : et);
		if (upd)
			ref_tag[a[20:26]] = inv ? diag : et;
	endtask

	// Bus ownership and changeover gaps
	always @(negedge mclk)
	begin
		sw = bus_sw[0] ^ pol;
		if (resetn)
		begin
			if (data_oe && sw || mc_grant && !sw || bus_sw[0] !== bus_sw[1])
				chk("bus_fight", 1, 0);
			if (sw && !sw_q)
				chk("close_gap", oe_off >= 2 + ctrl[5:4], 1);
			if (mc_grant && !gr_q)
				chk("grant_gap", sw_cl >= 2 + ctrl[5:4] && sw_cl >= 1 + tim[3:0], 1);
			if (data_oe && !oe_q)
				chk("open_gap", sw_op >= 2 + ctrl[5:4], 1);
			if (!tag_oe_n && to_q)
				chk("reopen_gap", gr_off >= 2 * (tim[7:4] + 2), 1);
		end
		oe_off = data_oe ? 0 : oe_off + 1;
		sw_cl = sw ? sw_cl + 1 : 0;
		sw_op = sw ? 0 : sw_op + 1;
		gr_off = mc_grant ? 0 : gr_off + 1;
		{sw_q, oe_q, gr_q, to_q} = {sw, data_oe, mc_grant, tag_oe_n};
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] d;
		logic [0:28] a, b;
		void'($urandom(32'hf1da));
		for (int i = 0; i < 128; i++)
			ref_tag[i] = 15'h7fff;
		repeat (6) @(posedge mclk);
		chk("reset_outs", {txn_ready, tag_oe_n, bus_sw, data_oe, mc_grant}, 6'h30);
		resetn <= 1'b1;
		rd(l2c_pkg::OFF_CTRL, d);
		chk("ctrl_reset", d, 32'h2);
		rd(l2c_pkg::OFF_DIAGNOSTIC_TAG_PATTERN, d);
		chk("diag_reset", d, 32'h7fff);
		rd(l2c_pkg::OFF_TIMING, d);
		chk("timing_reset", d, 32'h0);
		rd(8'hfc, d);
		chk("unmapped", d, 32'h0);
		rd(l2c_pkg::OFF_STATUS, d);
		chk("status_idle", d, 32'h0);
		wr(l2c_pkg::OFF_DIAGNOSTIC_TAG_PATTERN, 32'h7fff);
		// Every kind after a fill of the same line
		a = 29'h0468ace;
		b = a ^ 29'h8000000;
		for (int k = 0; k < 8; k++)
		begin
			txn(3'h0, a);
			txn(3'(k), a);
		end
		ctrl[0] = 1'b1;
		wr(l2c_pkg::OFF_CTRL, {18'h0, ctrl});
		txn(l2c_pkg::KIND_CASTOUT, b);
		txn(3'h0, b);
		// Bad parity: first error kept, later ones not
		flip_par = 1'b1;
		txn(3'h0, b);
		txn(3'h0, a);
		flip_par = 1'b0;
		rd(l2c_pkg::OFF_LOG_ADDR, d);
		chk("log_addr", d, {3'h0, b});
		rd(l2c_pkg::OFF_LOG_TAG, d);
		chk("log_tag", {d[17], d[14:0]}, {1'b1, exp_tag(b) ^ 15'h1});
		wr(l2c_pkg::OFF_LOG_TAG, 32'h0);
		ctrl[1] = 1'b0;
		wr(l2c_pkg::OFF_CTRL, {18'h0, ctrl});
		flip_par = 1'b1;
		txn(3'h0, a);
		flip_par = 1'b0;
		// Forced pattern for compare, write and logging
		ctrl[2] = 1'b1;
		diag = 15'h2aaa;
		wr(l2c_pkg::OFF_DIAGNOSTIC_TAG_PATTERN, {17'h0, diag});
		wr(l2c_pkg::OFF_CTRL, {18'h0, ctrl});
		txn(3'h0, a);
		txn(3'h0, b);
		rd(l2c_pkg::OFF_LOG_TAG, d);
		chk("log_forced", {d[17:16], d[14:0]}, {2'h3, diag});
		diag = 15'h7fff;
		wr(l2c_pkg::OFF_DIAGNOSTIC_TAG_PATTERN, {17'h0, diag});
		// Random kinds, addresses, gaps, polarity and split
		for (int n = 0; n < 80; n++)
		begin
			if (n % 10 == 0)
			begin
				ctrl = (14'($urandom) | 14'h0002) & 14'h3ffb;
				tim = 8'($urandom);
				wr(l2c_pkg::OFF_CTRL, {18'h0, ctrl});
				wr(l2c_pkg::OFF_TIMING, {24'h0, tim});
				rd(l2c_pkg::OFF_CTRL, d);
				chk("ctrl_back", d, {18'h0, ctrl});
			end
			a = 29'($urandom);
			a[0:13] = 14'($urandom % 3);
			a[20:26] = 7'($urandom % 4);
			txn(3'($urandom), a);
		end
		results;
	end
endmodule
`default_nettype wire
